// [dapc_map.vh]
// Constants for the dual converter control-pin decoder.
`ifndef DAPC_MAP_VH
`define DAPC_MAP_VH
`define DAPC_CLK_HZ 20000000
`define DAPC_CAL_LOW_CYC 80
`define DAPC_CAL_HIGH_CYC 80
`define DAPC_CALIBRATION_ACTIVE_CYC 16
`define DAPC_RANGE_SMALL_MV 650
`define DAPC_RANGE_LARGE_MV 870
`define DAPC_REG_CTRL 32'h00000000
`define DAPC_REG_STATUS 32'h00000004
`define DAPC_REG_IRQ_STAT 32'h00000008
`define DAPC_REG_IRQ_MASK 32'h0000000C
`define DAPC_REG_CONFIG 32'h00000010
`define DAPC_CTRL_INTERLEAVE 0
`define DAPC_CTRL_RESET 8'h00
`define DAPC_ST_EXT 0
`define DAPC_ST_RANGE 1
`define DAPC_ST_SWING 2
`define DAPC_ST_EDGE 3
`define DAPC_ST_DDR 4
`define DAPC_ST_PWR_DN 5
`define DAPC_ST_Q_DN 6
`define DAPC_ST_CAL 7
`define DAPC_IRQ_CAL_DONE 0
`define DAPC_IRQ_CLK_SYNC 1
`define DAPC_IRQ_CFG_WORD 2
`define DAPC_IRQ_WIDTH 3
`define DAPC_IRQ_RESET 3'h0
`define DAPC_CFG_BITS 16
`endif

// [dapc_sync.v]
// Two-stage synchroniser for a group of control pins.
`timescale 1ns/1ns
module dapc_sync #(
    parameter W = 1
) (
    input wire clk_i,
    input wire rst_i,
    input wire [W-1:0] d_i,
    output reg [W-1:0] q_o
);
    reg [W-1:0] meta;
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta <= {W{1'b0}};
            q_o <= {W{1'b0}};
        end
        else
        begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule

// [dapc_top.v]
// Control-pin decoder, sample demultiplexer and register slave of a dual 8-bit converter.
// Function
// - Calibration starts only after trigger low 80 cycles then high 80 cycles.
// - Outside extended mode, range pin low gives small range, high large.
// - Range pin at mid level enters extended mode; serial registers govern configuration.
// - Outside extended mode, swing pin high normal swing, low reduced swing.
// - In extended mode the swing pin is the serial interface clock.
// - Outside extended mode, edge pin logic level picks output clock edge.
// - Edge pin at mid level selects double data rate output clocking.
// - In extended mode the edge pin is the serial data input.
// - Positive pulse on clock sync reset restarts the output clock divider.
// - While power-down pin high, the whole device is powered down.
// - While Q power-down pin high, only Q channel stops outside interleave mode; I keeps converting.
// - Each channel demultiplexes one-to-two onto two buses at half rate.
// - Each sample is an 8-bit offset binary word.
// - Interleave mode samples one input on both converters, so both channels carry the same samples.
// - Calibration-active output is high exactly while calibration runs.
// - In extended mode, delay pin is serial chip select; delay defaults short.
// - Samples are taken on the falling edge of the input clock's positive leg.
`timescale 1ns/1ns
`include "dapc_map.vh"
module dapc_top (
    input wire CORE_CLK_I,
    input wire RST_I,
    input wire [31:0] ADR_I,
    input wire [31:0] DAT_I,
    input wire [3:0] SEL_I,
    input wire WE_I,
    input wire CYC_I,
    input wire STB_I,
    output reg [31:0] DAT_O,
    output reg ACK_O,
    output reg INT_O,
    input wire INPUT_RANGE_SELECT_HI_I,
    input wire INPUT_RANGE_SELECT_MID_I,
    input wire OUTPUT_SWING_SELECT_I,
    input wire OUTPUT_EDGE_SELECT_HI_I,
    input wire OUTPUT_EDGE_SELECT_MID_I,
    input wire CALIBRATION_DELAY_SELECT_I,
    input wire CALIBRATION_TRIGGER_I,
    input wire OUTPUT_CLOCK_SYNC_RESET_I,
    input wire DEVICE_POWER_DOWN_I,
    input wire Q_CHANNEL_POWER_DOWN_I,
    input wire [7:0] I_SAMPLE_I,
    input wire [7:0] Q_SAMPLE_I,
    input wire SAMPLE_STROBE_I,
    output reg CALIBRATION_ACTIVE_O,
    output reg OUTPUT_DATA_CLOCK_O,
    output reg [7:0] I_BUS_A_O,
    output reg [7:0] I_BUS_B_O,
    output reg [7:0] Q_BUS_A_O,
    output reg [7:0] Q_BUS_B_O,
    output reg RANGE_LARGE_O,
    output reg SWING_NORMAL_O,
    output reg EDGE_RISING_O,
    output reg DDR_MODE_O,
    output reg EXTENDED_CONTROL_ENABLE_O,
    output reg DEVICE_POWERED_DOWN_O,
    output reg Q_POWERED_DOWN_O
);
    localparam CAL_IDLE = 2'b00;
    localparam CAL_LOW = 2'b01;
    localparam CAL_HIGH = 2'b10;
    localparam CAL_RUN = 2'b11;

    wire [9:0] pins;
    reg [7:0] ctrl;
    reg [`DAPC_IRQ_WIDTH-1:0] irq_stat;
    reg [`DAPC_IRQ_WIDTH-1:0] irq_mask;
    reg [1:0] cal_state;
    reg [7:0] cal_cnt;
    reg sclk_d;
    reg osr_d;
    reg [15:0] cfg_shift;
    reg [15:0] cfg_word;
    reg [4:0] cfg_cnt;
    reg demux_phase;
    reg [7:0] i_hold;
    reg [7:0] q_hold;
    reg [7:0] next_dat;
    reg [`DAPC_IRQ_WIDTH-1:0] ev;
    wire ext;
    wire pwr_dn;
    wire q_dn;
    wire range_s;
    wire range_m;
    wire swing;
    wire edge_h;
    wire edge_m;
    wire dly;
    wire trig;
    wire osr;
    wire bus_req;

    // Raw pins are asynchronous to the core clock.
    dapc_sync #(.W(10)) u_sync (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .d_i({INPUT_RANGE_SELECT_HI_I, INPUT_RANGE_SELECT_MID_I, OUTPUT_SWING_SELECT_I,
              OUTPUT_EDGE_SELECT_HI_I, OUTPUT_EDGE_SELECT_MID_I, CALIBRATION_DELAY_SELECT_I,
              CALIBRATION_TRIGGER_I, OUTPUT_CLOCK_SYNC_RESET_I, DEVICE_POWER_DOWN_I,
              Q_CHANNEL_POWER_DOWN_I}),
        .q_o(pins)
    );
    assign range_s = pins[9];
    assign range_m = pins[8];
    assign swing = pins[7];
    assign edge_h = pins[6];
    assign edge_m = pins[5];
    assign dly = pins[4];
    assign trig = pins[3];
    assign osr = pins[2];
    assign pwr_dn = pins[1];
    assign q_dn = pins[0];
    assign ext = range_m;
    assign bus_req = CYC_I & STB_I & ~ACK_O;

    function [31:0] word_addr;
        input [31:0] a;
        begin
            word_addr = {a[31:2], 2'b00};
        end
    endfunction

    // Pin decode into mode outputs.
    always @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            RANGE_LARGE_O <= 1'b0;
            SWING_NORMAL_O <= 1'b1;
            EDGE_RISING_O <= 1'b0;
            DDR_MODE_O <= 1'b0;
            EXTENDED_CONTROL_ENABLE_O <= 1'b0;
            DEVICE_POWERED_DOWN_O <= 1'b0;
            Q_POWERED_DOWN_O <= 1'b0;
        end
        else
        begin
            EXTENDED_CONTROL_ENABLE_O <= ext;
            if (!ext)
            begin
                RANGE_LARGE_O <= range_s;
                SWING_NORMAL_O <= swing;
                if (!edge_m)
                    EDGE_RISING_O <= edge_h;
                DDR_MODE_O <= edge_m;
            end
            else
            begin
                // Serial words rule here: low bits of the last word set the modes.
                RANGE_LARGE_O <= cfg_word[0];
                SWING_NORMAL_O <= cfg_word[1];
                EDGE_RISING_O <= cfg_word[2];
                DDR_MODE_O <= cfg_word[3];
            end
            DEVICE_POWERED_DOWN_O <= pwr_dn;
            Q_POWERED_DOWN_O <= pwr_dn | q_dn;
        end
    end

    // Serial port in extended mode; the clock detector idles high so a frame cannot open on a false edge.
    always @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            sclk_d <= 1'b1;
            cfg_shift <= 16'h0000;
            cfg_word <= 16'h0003;
            cfg_cnt <= 5'h00;
        end
        else
        begin
            sclk_d <= (ext && dly) ? swing : 1'b1;
            if (!ext || !dly)
                cfg_cnt <= 5'h00;
            else if (swing && !sclk_d)
            begin
                cfg_shift <= {cfg_shift[14:0], edge_h};
                if (cfg_cnt == `DAPC_CFG_BITS - 1)
                begin
                    cfg_word <= {cfg_shift[14:0], edge_h};
                    cfg_cnt <= 5'h00;
                end
                else
                    cfg_cnt <= cfg_cnt + 5'h01;
            end
        end
    end

    // Calibration trigger: a long low followed by a long high starts the sequence.
    always @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            cal_state <= CAL_IDLE;
            cal_cnt <= 8'h00;
            CALIBRATION_ACTIVE_O <= 1'b0;
        end
        else
        begin
            case (cal_state)
                CAL_IDLE:
                begin
                    cal_cnt <= 8'h00;
                    if (!trig && !pwr_dn)
                        cal_state <= CAL_LOW;
                end
                CAL_LOW:
                begin
                    if (trig)
                    begin
                        cal_state <= (cal_cnt >= `DAPC_CAL_LOW_CYC) ? CAL_HIGH : CAL_IDLE;
                        cal_cnt <= 8'h01;
                    end
                    else if (cal_cnt < `DAPC_CAL_LOW_CYC)
                        cal_cnt <= cal_cnt + 8'h01;
                end
                CAL_HIGH:
                begin
                    if (!trig)
                    begin
                        cal_state <= CAL_LOW;
                        cal_cnt <= 8'h01;
                    end
                    else if (cal_cnt == `DAPC_CAL_HIGH_CYC - 1)
                    begin
                        cal_state <= CAL_RUN;
                        cal_cnt <= 8'h00;
                        CALIBRATION_ACTIVE_O <= 1'b1;
                    end
                    else
                        cal_cnt <= cal_cnt + 8'h01;
                end
                CAL_RUN:
                begin
                    // Short delay only: a long power-up delay is not modelled.
                    if (cal_cnt == `DAPC_CALIBRATION_ACTIVE_CYC - 1)
                    begin
                        cal_state <= CAL_IDLE;
                        CALIBRATION_ACTIVE_O <= 1'b0;
                    end
                    else
                        cal_cnt <= cal_cnt + 8'h01;
                end
                default:
                    cal_state <= CAL_IDLE;
            endcase
        end
    end

    // Sample path: each strobe is a falling edge of the input clock's positive leg.
    always @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            osr_d <= 1'b0;
            demux_phase <= 1'b0;
            i_hold <= 8'h00;
            q_hold <= 8'h00;
            I_BUS_A_O <= 8'h00;
            I_BUS_B_O <= 8'h00;
            Q_BUS_A_O <= 8'h00;
            Q_BUS_B_O <= 8'h00;
            OUTPUT_DATA_CLOCK_O <= 1'b0;
        end
        else
        begin
            osr_d <= osr;
            if (osr && !osr_d)
            begin
                demux_phase <= 1'b0;
                OUTPUT_DATA_CLOCK_O <= 1'b0;
            end
            else if (SAMPLE_STROBE_I && !pwr_dn && !CALIBRATION_ACTIVE_O)
            begin
                demux_phase <= ~demux_phase;
                if (!demux_phase)
                begin
                    i_hold <= I_SAMPLE_I;
                    q_hold <= ctrl[`DAPC_CTRL_INTERLEAVE] ? I_SAMPLE_I : Q_SAMPLE_I;
                end
                else
                begin
                    // Both buses of a channel update together at half the sample rate.
                    I_BUS_A_O <= i_hold;
                    I_BUS_B_O <= I_SAMPLE_I;
                    if (ctrl[`DAPC_CTRL_INTERLEAVE])
                    begin
                        Q_BUS_A_O <= q_hold;
                        Q_BUS_B_O <= I_SAMPLE_I;
                    end
                    else if (!q_dn)
                    begin
                        Q_BUS_A_O <= q_hold;
                        Q_BUS_B_O <= Q_SAMPLE_I;
                    end
                    OUTPUT_DATA_CLOCK_O <= ~OUTPUT_DATA_CLOCK_O;
                end
            end
        end
    end

    // Wishbone read mux.
    always @*
    begin
        next_dat = 8'h00;
        case (word_addr(ADR_I))
            `DAPC_REG_CTRL: next_dat = ctrl;
            `DAPC_REG_STATUS: next_dat = {CALIBRATION_ACTIVE_O, Q_POWERED_DOWN_O, DEVICE_POWERED_DOWN_O,
                                          DDR_MODE_O, EDGE_RISING_O, SWING_NORMAL_O, RANGE_LARGE_O,
                                          EXTENDED_CONTROL_ENABLE_O};
            `DAPC_REG_IRQ_STAT: next_dat = {5'h00, irq_stat};
            `DAPC_REG_IRQ_MASK: next_dat = {5'h00, irq_mask};
            default: next_dat = 8'h00;
        endcase
    end

    always @*
    begin
        ev = 3'h0;
        ev[`DAPC_IRQ_CAL_DONE] = (cal_state == CAL_RUN) && (cal_cnt == `DAPC_CALIBRATION_ACTIVE_CYC - 1);
        ev[`DAPC_IRQ_CLK_SYNC] = osr && !osr_d;
        ev[`DAPC_IRQ_CFG_WORD] = ext && dly && swing && !sclk_d && (cfg_cnt == `DAPC_CFG_BITS - 1);
    end

    // Wishbone slave: one wait cycle, ack for one cycle, unmapped reads give zero.
    always @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h00000000;
            ctrl <= `DAPC_CTRL_RESET;
            irq_stat <= `DAPC_IRQ_RESET;
            irq_mask <= `DAPC_IRQ_RESET;
            INT_O <= 1'b0;
        end
        else
        begin
            ACK_O <= bus_req;
            DAT_O <= bus_req && !WE_I ? {24'h000000, next_dat} : 32'h00000000;
            if (bus_req && WE_I && SEL_I[0])
            begin
                if (word_addr(ADR_I) == `DAPC_REG_CTRL)
                    ctrl <= DAT_I[7:0];
                if (word_addr(ADR_I) == `DAPC_REG_IRQ_MASK)
                    irq_mask <= DAT_I[2:0];
            end
            // A new event wins over a write-one-to-clear in the same cycle.
            if (bus_req && WE_I && SEL_I[0] && word_addr(ADR_I) == `DAPC_REG_IRQ_STAT)
                irq_stat <= (irq_stat & ~DAT_I[2:0]) | ev;
            else
                irq_stat <= irq_stat | ev;
            INT_O <= |(irq_stat & irq_mask);
        end
    end
endmodule

// [dapc_chk.sv]
// Concurrent assertions on the ports of the converter control-pin decoder.
`timescale 1ns/1ns
module dapc_chk (
    input wire CORE_CLK_I,
    input wire RST_I,
    input wire CYC_I,
    input wire STB_I,
    input wire ACK_O,
    input wire INPUT_RANGE_SELECT_HI_I,
    input wire INPUT_RANGE_SELECT_MID_I,
    input wire OUTPUT_SWING_SELECT_I,
    input wire OUTPUT_EDGE_SELECT_MID_I,
    input wire CALIBRATION_TRIGGER_I,
    input wire OUTPUT_CLOCK_SYNC_RESET_I,
    input wire DEVICE_POWER_DOWN_I,
    input wire CALIBRATION_ACTIVE_O,
    input wire OUTPUT_DATA_CLOCK_O,
    input wire RANGE_LARGE_O,
    input wire SWING_NORMAL_O,
    input wire DDR_MODE_O,
    input wire EXTENDED_CONTROL_ENABLE_O,
    input wire DEVICE_POWERED_DOWN_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    // The pin checks wait until the synchronisers hold pin values, not reset values.
    reg [2:0] up;
    reg [4:0] run;
    reg [7:0] hi;
    always @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            up <= 3'h0;
            run <= 5'h00;
            hi <= 8'h00;
        end
        else
        begin
            up <= (up == 3'h4) ? up : up + 3'h1;
            run <= CALIBRATION_ACTIVE_O ? run + 5'h01 : 5'h00;
            hi <= !CALIBRATION_TRIGGER_I ? 8'h00 : ((hi == 8'hFF) ? hi : hi + 8'h01);
        end
    end
    ack_answer_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("bus request not acknowledged");
    range_decode_a: assert property (
        up == 3'h4 && !$past(INPUT_RANGE_SELECT_MID_I, 3) |-> RANGE_LARGE_O == $past(INPUT_RANGE_SELECT_HI_I, 3))
        else $error("range decode wrong");
    ext_mode_a: assert property (
        up == 3'h4 |-> EXTENDED_CONTROL_ENABLE_O == $past(INPUT_RANGE_SELECT_MID_I, 3))
        else $error("extended mode decode wrong");
    swing_decode_a: assert property (
        up == 3'h4 && !$past(INPUT_RANGE_SELECT_MID_I, 3) |-> SWING_NORMAL_O == $past(OUTPUT_SWING_SELECT_I, 3))
        else $error("swing decode wrong");
    ddr_decode_a: assert property (
        up == 3'h4 && !$past(INPUT_RANGE_SELECT_MID_I, 3) |-> DDR_MODE_O == $past(OUTPUT_EDGE_SELECT_MID_I, 3))
        else $error("double rate decode wrong");
    power_down_a: assert property (
        up == 3'h4 |-> DEVICE_POWERED_DOWN_O == $past(DEVICE_POWER_DOWN_I, 3))
        else $error("power down decode wrong");
    cal_length_a: assert property ($fell(CALIBRATION_ACTIVE_O) |-> run == 5'h10)
        else $error("calibration run length wrong");
    cal_trigger_a: assert property ($rose(CALIBRATION_ACTIVE_O) |-> hi >= 8'h50)
        else $error("calibration started without long high");
    clock_sync_a: assert property ($rose(OUTPUT_CLOCK_SYNC_RESET_I) |-> ##[2:4] !OUTPUT_DATA_CLOCK_O)
        else $error("output clock not cleared");
endmodule
bind dapc_top dapc_chk chk_u (
    .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O),
    .INPUT_RANGE_SELECT_HI_I(INPUT_RANGE_SELECT_HI_I), .INPUT_RANGE_SELECT_MID_I(INPUT_RANGE_SELECT_MID_I),
    .OUTPUT_SWING_SELECT_I(OUTPUT_SWING_SELECT_I), .OUTPUT_EDGE_SELECT_MID_I(OUTPUT_EDGE_SELECT_MID_I),
    .CALIBRATION_TRIGGER_I(CALIBRATION_TRIGGER_I), .OUTPUT_CLOCK_SYNC_RESET_I(OUTPUT_CLOCK_SYNC_RESET_I),
    .DEVICE_POWER_DOWN_I(DEVICE_POWER_DOWN_I), .CALIBRATION_ACTIVE_O(CALIBRATION_ACTIVE_O),
    .OUTPUT_DATA_CLOCK_O(OUTPUT_DATA_CLOCK_O), .RANGE_LARGE_O(RANGE_LARGE_O), .SWING_NORMAL_O(SWING_NORMAL_O),
    .DDR_MODE_O(DDR_MODE_O), .EXTENDED_CONTROL_ENABLE_O(EXTENDED_CONTROL_ENABLE_O),
    .DEVICE_POWERED_DOWN_O(DEVICE_POWERED_DOWN_O)
);

// [dapc_host.sv]
// Host controller model that drives the converter's strap, trigger and sample pins.
`timescale 1ns/1ns
module dapc_host (
    input wire clk_i,
    output reg [9:0] pins_o,
    output reg [7:0] i_o,
    output reg [7:0] q_o,
    output reg stb_o
);
    // Pin order: q down, down, sync, trigger, delay, edge mid, edge, swing, range mid, range.
    initial
    begin
        pins_o = 10'h044;
        i_o = 8'h00;
        q_o = 8'h00;
        stb_o = 1'b0;
    end
    task wait_cyc(input integer n);
        repeat (n) @(posedge clk_i);
    endtask
    task set_pins(input [9:0] p);
        pins_o <= p;
    endtask
    // The trigger is left high, so the caller decides how long the high phase lasts.
    task cal(input integer lo);
        pins_o[6] <= 1'b0;
        wait_cyc(lo);
        pins_o[6] <= 1'b1;
    endtask
    task sync_pulse;
        pins_o[7] <= 1'b1;
        wait_cyc(4);
        pins_o[7] <= 1'b0;
    endtask
    // Lines that are no longer valid carry inverted data so stale values cannot pass.
    task pair(input [7:0] a, input [7:0] b, input [7:0] qa, input [7:0] qb);
        i_o <= a;
        q_o <= qa;
        stb_o <= 1'b1;
        wait_cyc(1);
        i_o <= b;
        q_o <= qb;
        wait_cyc(1);
        stb_o <= 1'b0;
        i_o <= ~b;
        q_o <= ~qb;
    endtask
    task shift(input [15:0] w);
        integer k;
        pins_o[5] <= 1'b1;
        for (k = 15; k >= 0; k = k - 1)
        begin
            pins_o[3] <= w[k];
            pins_o[2] <= 1'b0;
            wait_cyc(4);
            pins_o[2] <= 1'b1;
            wait_cyc(4);
        end
        pins_o[5] <= 1'b0;
        pins_o[3] <= ~w[0];
    endtask
endmodule

// [test_dual_adc_pin_mode_control.sv]
// Self-checking bench for the converter control-pin decoder.
`timescale 1ns/1ns
`include "dapc_map.vh"
module test_dual_adc_pin_mode_control;
    reg CORE_CLK_I, RST_I, WE_I, CYC_I, STB_I;
    reg [31:0] ADR_I, DAT_I;
    reg [3:0] SEL_I;
    wire [31:0] DAT_O;
    wire ACK_O, INT_O, CALIBRATION_ACTIVE_O, OUTPUT_DATA_CLOCK_O, SAMPLE_STROBE_I;
    wire [7:0] I_BUS_A_O, I_BUS_B_O, Q_BUS_A_O, Q_BUS_B_O, I_SAMPLE_I, Q_SAMPLE_I;
    wire RANGE_LARGE_O, SWING_NORMAL_O, EDGE_RISING_O, DDR_MODE_O, EXTENDED_CONTROL_ENABLE_O;
    wire DEVICE_POWERED_DOWN_O, Q_POWERED_DOWN_O, INPUT_RANGE_SELECT_HI_I, INPUT_RANGE_SELECT_MID_I;
    wire OUTPUT_SWING_SELECT_I, OUTPUT_EDGE_SELECT_HI_I, OUTPUT_EDGE_SELECT_MID_I, CALIBRATION_DELAY_SELECT_I;
    wire CALIBRATION_TRIGGER_I, OUTPUT_CLOCK_SYNC_RESET_I, DEVICE_POWER_DOWN_I, Q_CHANNEL_POWER_DOWN_I;
    wire [9:0] p;
    reg [9:0] tbl [0:3];
    reg [31:0] r, e;
    integer fails, num_checks, k;
    assign {Q_CHANNEL_POWER_DOWN_I, DEVICE_POWER_DOWN_I, OUTPUT_CLOCK_SYNC_RESET_I, CALIBRATION_TRIGGER_I,
        CALIBRATION_DELAY_SELECT_I, OUTPUT_EDGE_SELECT_MID_I, OUTPUT_EDGE_SELECT_HI_I, OUTPUT_SWING_SELECT_I,
        INPUT_RANGE_SELECT_MID_I, INPUT_RANGE_SELECT_HI_I} = p;
    dapc_top dut_u (
        .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .ADR_I(ADR_I), .DAT_I(DAT_I), .SEL_I(SEL_I), .WE_I(WE_I),
        .CYC_I(CYC_I), .STB_I(STB_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .INT_O(INT_O),
        .INPUT_RANGE_SELECT_HI_I(INPUT_RANGE_SELECT_HI_I), .INPUT_RANGE_SELECT_MID_I(INPUT_RANGE_SELECT_MID_I),
        .OUTPUT_SWING_SELECT_I(OUTPUT_SWING_SELECT_I), .OUTPUT_EDGE_SELECT_HI_I(OUTPUT_EDGE_SELECT_HI_I),
        .OUTPUT_EDGE_SELECT_MID_I(OUTPUT_EDGE_SELECT_MID_I), .CALIBRATION_DELAY_SELECT_I(CALIBRATION_DELAY_SELECT_I),
        .CALIBRATION_TRIGGER_I(CALIBRATION_TRIGGER_I), .OUTPUT_CLOCK_SYNC_RESET_I(OUTPUT_CLOCK_SYNC_RESET_I),
        .DEVICE_POWER_DOWN_I(DEVICE_POWER_DOWN_I), .Q_CHANNEL_POWER_DOWN_I(Q_CHANNEL_POWER_DOWN_I),
        .I_SAMPLE_I(I_SAMPLE_I), .Q_SAMPLE_I(Q_SAMPLE_I), .SAMPLE_STROBE_I(SAMPLE_STROBE_I),
        .CALIBRATION_ACTIVE_O(CALIBRATION_ACTIVE_O), .OUTPUT_DATA_CLOCK_O(OUTPUT_DATA_CLOCK_O),
        .I_BUS_A_O(I_BUS_A_O), .I_BUS_B_O(I_BUS_B_O), .Q_BUS_A_O(Q_BUS_A_O), .Q_BUS_B_O(Q_BUS_B_O),
        .RANGE_LARGE_O(RANGE_LARGE_O), .SWING_NORMAL_O(SWING_NORMAL_O), .EDGE_RISING_O(EDGE_RISING_O),
        .DDR_MODE_O(DDR_MODE_O), .EXTENDED_CONTROL_ENABLE_O(EXTENDED_CONTROL_ENABLE_O),
        .DEVICE_POWERED_DOWN_O(DEVICE_POWERED_DOWN_O), .Q_POWERED_DOWN_O(Q_POWERED_DOWN_O)
    );
    dapc_host host_u (.clk_i(CORE_CLK_I), .pins_o(p), .i_o(I_SAMPLE_I), .q_o(Q_SAMPLE_I), .stb_o(SAMPLE_STROBE_I));
    initial
    begin
        CORE_CLK_I = 1'b0;
        forever #25 CORE_CLK_I = ~CORE_CLK_I;
    end
    task summarize;
        if (fails == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input [8*10-1:0] n, input [31:0] s, input [31:0] x);
        num_checks = num_checks + 1;
        if (s !== x)
        begin
            fails = fails + 1;
            $display("wrong value %0s expected %h seen %h", n, x, s);
        end
    endtask
    task wb(input [31:0] a, input w, input [31:0] d);
        integer n;
        ADR_I <= a;
        WE_I <= w;
        DAT_I <= d;
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        n = 0;
        @(posedge CORE_CLK_I);
        while (ACK_O !== 1'b1 && n < 20)
        begin
            n = n + 1;
            @(posedge CORE_CLK_I);
        end
        if (n == 20)
        begin
            fails = fails + 1;
            summarize;
        end
        r = DAT_O;
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        @(posedge CORE_CLK_I);
    endtask
    task rchk(input [31:0] a, input [31:0] x, input [8*10-1:0] n);
        wb(a, 1'b0, 32'h0);
        chk(n, r, x);
    endtask
    task pair_chk(input [31:0] x, input c);
        host_u.wait_cyc(3);
        chk("buses", {I_BUS_A_O, I_BUS_B_O, Q_BUS_A_O, Q_BUS_B_O}, x);
        chk("out_clk", {31'h0, OUTPUT_DATA_CLOCK_O}, {31'h0, c});
    endtask
    initial
    begin
        {RST_I, WE_I, CYC_I, STB_I, ADR_I, DAT_I} = {1'b1, 67'h0};
        SEL_I = 4'hF;
        {fails, num_checks} = 64'h0;
        {tbl[0], tbl[1], tbl[2], tbl[3]} = {10'h044, 10'h049, 10'h155, 10'h24C};
        repeat (6) @(posedge CORE_CLK_I);
        RST_I <= 1'b0;
        rchk(`DAPC_REG_CTRL, 32'h0, "ctrl");
        rchk(`DAPC_REG_IRQ_STAT, 32'h0, "irq_stat");
        rchk(`DAPC_REG_IRQ_MASK, 32'h0, "irq_mask");
        wb(32'h00000040, 1'b1, 32'h000000FF);
        rchk(32'h00000040, 32'h0, "unmapped");
        SEL_I <= 4'h0;
        wb(`DAPC_REG_IRQ_MASK, 1'b1, 32'h00000007);
        SEL_I <= 4'hF;
        rchk(`DAPC_REG_IRQ_MASK, 32'h0, "sel_off");
        // Edge selection is not compared while the edge pin sits at mid level.
        for (k = 0; k < 4; k = k + 1)
        begin
            host_u.set_pins(tbl[k]);
            host_u.wait_cyc(5);
            // A whole-device power down takes the Q channel down as well.
            e = {25'h0, tbl[k][9] | tbl[k][8], tbl[k][8], tbl[k][4], tbl[k][3] & ~tbl[k][4],
                tbl[k][2], tbl[k][0], 1'b0};
            chk("pins", {25'h0, Q_POWERED_DOWN_O, DEVICE_POWERED_DOWN_O, DDR_MODE_O, EDGE_RISING_O & ~tbl[k][4],
                SWING_NORMAL_O, RANGE_LARGE_O, EXTENDED_CONTROL_ENABLE_O}, e);
            wb(`DAPC_REG_STATUS, 1'b0, 32'h0);
            chk("status", r & ~{27'h0, tbl[k][4], 3'h0}, e);
        end
        host_u.set_pins(10'h044);
        host_u.wait_cyc(5);
        host_u.cal(40);
        r = 32'h0;
        repeat (120) @(posedge CORE_CLK_I) r = r | CALIBRATION_ACTIVE_O;
        chk("cal_short", r, 32'h0);
        host_u.cal(85);
        for (k = 0; CALIBRATION_ACTIVE_O !== 1'b1 && k < 120; k = k + 1) @(posedge CORE_CLK_I);
        chk("cal_start", k >= 80 && k <= 86, 32'h1);
        for (k = 0; CALIBRATION_ACTIVE_O === 1'b1 && k < 40; k = k + 1) @(posedge CORE_CLK_I);
        chk("cal_len", k, 32'h10);
        host_u.wait_cyc(2);
        chk("int_off", INT_O, 32'h0);
        rchk(`DAPC_REG_IRQ_STAT, 32'h1, "irq_cal");
        wb(`DAPC_REG_IRQ_MASK, 1'b1, 32'h1);
        host_u.wait_cyc(2);
        chk("int_on", INT_O, 32'h1);
        wb(`DAPC_REG_IRQ_STAT, 1'b1, 32'h1);
        host_u.wait_cyc(2);
        chk("int_clr", INT_O, 32'h0);
        host_u.pair(8'h00, 8'hFF, 8'h80, 8'h7F);
        pair_chk(32'h00FF807F, 1'b1);
        host_u.set_pins(10'h244);
        host_u.wait_cyc(4);
        host_u.pair(8'h11, 8'h22, 8'h33, 8'h44);
        pair_chk(32'h1122807F, 1'b0);
        host_u.set_pins(10'h044);
        wb(`DAPC_REG_CTRL, 1'b1, 32'h1);
        host_u.wait_cyc(4);
        host_u.pair(8'h55, 8'h66, 8'h77, 8'h88);
        pair_chk(32'h55665566, 1'b1);
        host_u.set_pins(10'h144);
        host_u.wait_cyc(4);
        host_u.pair(8'h99, 8'hAA, 8'hBB, 8'hCC);
        pair_chk(32'h55665566, 1'b1);
        host_u.set_pins(10'h044);
        host_u.wait_cyc(4);
        host_u.sync_pulse;
        host_u.wait_cyc(4);
        chk("clk_sync", OUTPUT_DATA_CLOCK_O, 32'h0);
        rchk(`DAPC_REG_IRQ_STAT, 32'h2, "irq_sync");
        host_u.set_pins(10'h046);
        host_u.wait_cyc(5);
        chk("ext", EXTENDED_CONTROL_ENABLE_O, 32'h1);
        host_u.shift(16'h0005);
        host_u.wait_cyc(5);
        chk("serial", {DDR_MODE_O, EDGE_RISING_O, SWING_NORMAL_O, RANGE_LARGE_O}, 32'h5);
        rchk(`DAPC_REG_IRQ_STAT, 32'h6, "irq_cfg");
        summarize;
    end
endmodule
